// ---- txu_pkg.sv ----
package txu_pkg;
  // ==========================================================
  // register map (word aligned, apb byte addresses)
  localparam logic [7:0] TXU_REG_CTRL = 8'h00;
  localparam logic [7:0] TXU_REG_FLAGS = 8'h04;
  localparam logic [7:0] TXU_REG_STATUS = 8'h08;
  localparam logic [7:0] TXU_REG_USED = 8'h0C;
  localparam logic [7:0] TXU_REG_PEEK = 8'h10;

  // control register bits
  localparam int TXU_CTRL_STORE_FORWARD = 0;
  localparam int TXU_CTRL_DISCARD_OVERRUN = 1;
  localparam int TXU_CTRL_DEFER_CHECK = 2;
  localparam logic [2:0] TXU_CTRL_RESET = 3'h0;

  // flag register bits, write one to clear
  localparam int TXU_FLAG_TX_ERROR = 0;
  localparam int TXU_FLAG_UNDERRUN = 1;

  // ==========================================================
  // first command word layout
  localparam int TXU_CA_SIZE_LSB = 0;
  localparam int TXU_CA_SIZE_W = 11;
  localparam int TXU_CA_LAST = 12;
  localparam int TXU_CA_FIRST = 13;
  localparam int TXU_CA_OFFSET_LSB = 16;
  localparam int TXU_CA_OFFSET_W = 6;
  localparam int TXU_CA_ALIGN_LSB = 24;
  localparam int TXU_CA_ALIGN_W = 2;

  // end alignment codes
  localparam logic [1:0] TXU_ALIGN_4 = 2'h0;
  localparam logic [1:0] TXU_ALIGN_16 = 2'h1;
  localparam logic [1:0] TXU_ALIGN_32 = 2'h2;

  // second command word layout
  localparam int TXU_CB_LEN_LSB = 0;
  localparam int TXU_CB_TAG_LSB = 16;

  // ==========================================================
  // status word layout
  localparam int TXU_ST_TAG_LSB = 16;
  localparam int TXU_ST_ERROR_SUMMARY = 15;
  localparam int TXU_ST_LOST_CARRIER = 11;
  localparam int TXU_ST_NO_CARRIER = 10;
  localparam int TXU_ST_LATE_COLL = 9;
  localparam int TXU_ST_EXCESS_COLL = 8;
  localparam int TXU_ST_COLL_LSB = 3;
  localparam int TXU_ST_EXCESS_DEFER = 2;
  localparam int TXU_ST_UNDERRUN = 1;
  localparam int TXU_ST_DEFERRED = 0;

  // ==========================================================
  // sizes and limits
  localparam int TXU_STAT_DEPTH = 16;
  localparam int TXU_STAT_AW = 4;
  localparam logic [11:0] TXU_SF_LIMIT = 12'h7F4;

  typedef enum logic [2:0] {
    TXU_S_CMDA = 3'b000,
    TXU_S_CMDB = 3'b001,
    TXU_S_SKIP = 3'b010,
    TXU_S_DATA = 3'b011,
    TXU_S_EMIT = 3'b100,
    TXU_S_PAD = 3'b101
  } txu_state_e;
endpackage

// ---- txu_top.sv ----
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// R1 - first two words are commands, payload follows
// R2 - offset low bits pick first byte lane
// R3 - offset bits 5:2 skip whole words
// R4 - bytes past buffer end never reach mac
// R5 - end padding to 4/16/32 bytes dropped
// R6 - host pads buffer to its end alignment
// R7 - any byte start/end, edge buffers any length
// R8 - host keeps middle buffers four bytes minimum
// R9 - host limits store-forward use to 2036 bytes
// R10 - skip words, padding, commands consume no space
// R11 - one status word per packet in fifo
// R12 - pause transmission while status fifo full
// R13 - discard mode keeps transmitting when full
// R14 - discard overrun shows zero used, blocks writes
// R15 - discard overrun never raises transmitter error
// R16 - status top half carries packet tag
// R17 - error summary ORs bits 11,10,9,8,2,1
// R18 - bit 11 carrier lost, bit 10 no carrier
// R19 - bit 9 late collision abort
// R20 - bit 8 sixteen collisions, 6:3 count
// R21 - bit 2 excessive deferral, bit 0 deferred
// R22 - bit 1 underrun, also sets underrun flag
// R23 - summed sizes must match packet length
// R24 - command bit 13 first, bit 12 last
// R25 - reserved status bits read zero
module txu_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic buf_valid,
  input wire logic [31:0] buf_data,
  output logic buf_ready,
  output logic mac_valid,
  output logic [7:0] mac_data,
  output logic mac_last,
  input wire logic mac_ready,
  input wire logic stat_valid,
  input wire logic stat_lost_carrier,
  input wire logic stat_no_carrier,
  input wire logic stat_late_coll,
  input wire logic stat_excess_coll,
  input wire logic [3:0] stat_coll_count,
  input wire logic stat_excess_defer,
  input wire logic stat_underrun,
  input wire logic stat_deferred,
  output logic tx_pause
);
  import txu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    txu_state_e st;
    logic [31:0] cmd_a;
    logic [31:0] cmd_b;
    logic [31:0] first_b;
    logic [11:0] wcnt;
    logic [11:0] cnt;
    logic first_word;
    logic [31:0] hold;
    logic [1:0] lane;
    logic [1:0] last_lane;
    logic [11:0] sum_len;
    logic [11:0] sf_use;
    logic [15:0] pend_tag;
    logic [TXU_STAT_DEPTH-1:0][31:0] mem;
    logic [TXU_STAT_AW-1:0] wp;
    logic [TXU_STAT_AW-1:0] rp;
    logic [TXU_STAT_AW:0] used;
    logic ovr_block;
    logic tx_error;
    logic underrun;
    logic [2:0] ctrl;
    logic buf_ready;
    logic mac_valid;
    logic [7:0] mac_data;
    logic mac_last;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tx_pause;
  } txu_regs_s;

  txu_regs_s r;
  txu_regs_s n;

  // ==========================================================
  // helpers
  function automatic txu_state_e txu_after_data(input logic [11:0] w, input logic [1:0] al);
    logic [11:0] m;
    m = 12'h000;
    case (al)
      TXU_ALIGN_16: m = 12'h003;
      TXU_ALIGN_32: m = 12'h007;
      // code 3 is unused and behaves as four-byte alignment
      default: m = 12'h000;
    endcase
    // padding words end the buffer on the chosen boundary
    if ((w & m) == 12'h000) begin
      return TXU_S_CMDA;
    end
    return TXU_S_PAD; // [R5]
  endfunction

  logic [10:0] bsize;
  logic [1:0] lo;
  logic [3:0] skip;
  logic [1:0] align;
  logic is_last;
  logic is_first;
  logic [11:0] span;
  logic [11:0] dwords;
  logic [31:0] stat_word;
  logic take;
  logic fire;
  logic stat_full;
  logic stat_push;
  logic stat_pop;
  logic apb_wr;
  logic ctrl_wr;
  logic flags_wr;
  logic stat_lost;
  logic err_set;
  logic [31:0] peek;

  always_comb begin
    bsize = r.cmd_a[TXU_CA_SIZE_LSB +: TXU_CA_SIZE_W];
    lo = r.cmd_a[TXU_CA_OFFSET_LSB +: 2]; // [R2]
    skip = r.cmd_a[TXU_CA_OFFSET_LSB + 2 +: 4]; // [R3]
    align = r.cmd_a[TXU_CA_ALIGN_LSB +: TXU_CA_ALIGN_W];
    is_last = r.cmd_a[TXU_CA_LAST]; // [R24]
    is_first = r.cmd_a[TXU_CA_FIRST]; // [R24]
    span = {1'b0, bsize} + {10'h000, lo};
    // only words carrying payload bytes count, partial edges included
    dwords = (bsize == 11'h000) ? 12'h000 : ((span + 12'h003) >> 2); // [R7] [R10]
    stat_word = '0; // [R25]
    stat_word[TXU_ST_TAG_LSB +: 16] = r.pend_tag; // [R16]
    stat_word[TXU_ST_LOST_CARRIER] = stat_lost_carrier; // [R18]
    stat_word[TXU_ST_NO_CARRIER] = stat_no_carrier; // [R18]
    stat_word[TXU_ST_LATE_COLL] = stat_late_coll; // [R19]
    stat_word[TXU_ST_EXCESS_COLL] = stat_excess_coll; // [R20]
    stat_word[TXU_ST_COLL_LSB +: 4] = stat_coll_count; // [R20]
    stat_word[TXU_ST_EXCESS_DEFER] = stat_excess_defer & r.ctrl[TXU_CTRL_DEFER_CHECK]; // [R21]
    stat_word[TXU_ST_UNDERRUN] = stat_underrun; // [R22]
    stat_word[TXU_ST_DEFERRED] = stat_deferred; // [R21]
    stat_word[TXU_ST_ERROR_SUMMARY] = stat_word[TXU_ST_LOST_CARRIER] |
                                      stat_word[TXU_ST_NO_CARRIER] |
                                      stat_word[TXU_ST_LATE_COLL] |
                                      stat_word[TXU_ST_EXCESS_COLL] |
                                      stat_word[TXU_ST_EXCESS_DEFER] |
                                      stat_word[TXU_ST_UNDERRUN]; // [R17]
    take = buf_valid & r.buf_ready;
    fire = r.mac_valid & mac_ready;
    stat_full = (r.used == (TXU_STAT_AW + 1)'(TXU_STAT_DEPTH));
    // a pop needs a finished read, so the setup cycle never moves the head
    stat_pop = psel & penable & r.pready & ~pwrite & (paddr == TXU_REG_STATUS) & (r.used != '0);
    // a read in the same cycle frees the slot that the new word takes
    stat_push = stat_valid & (~stat_full | stat_pop) & ~r.ovr_block;
    stat_lost = stat_valid & stat_full & ~stat_pop;
    apb_wr = psel & penable & r.pready & pwrite;
    ctrl_wr = apb_wr & (paddr == TXU_REG_CTRL);
    flags_wr = apb_wr & (paddr == TXU_REG_FLAGS);
    peek = (r.used == '0) ? 32'h0 : r.mem[r.rp];
  end

  // ==========================================================
  // next state
  always_comb begin
    n = r;
    // error sources gather here so that a software clear cannot hide them
    err_set = 1'b0;
    if (fire) begin
      n.mac_valid = 1'b0;
      n.mac_last = 1'b0;
    end

    case (r.st)
      TXU_S_CMDA: begin
        if (take) begin
          n.cmd_a = buf_data;
          n.wcnt = 12'h001;
          n.st = TXU_S_CMDB;
        end
      end
      TXU_S_CMDB: begin
        if (take) begin
          n.cmd_b = buf_data;
          n.wcnt = r.wcnt + 12'h001;
          n.first_word = 1'b1;
          if (is_first) begin
            n.first_b = buf_data;
            n.sum_len = {1'b0, bsize};
            n.sf_use = dwords << 2;
          end else begin
            n.sum_len = r.sum_len + {1'b0, bsize};
            n.sf_use = r.sf_use + (dwords << 2);
            if (buf_data != r.first_b) begin
              err_set = 1'b1;
            end
          end
          // payload starts after both commands and any whole offset words
          if (skip != 4'h0) begin
            n.cnt = {8'h00, skip};
            n.st = TXU_S_SKIP; // [R1]
          end else if (dwords != 12'h000) begin
            n.cnt = dwords;
            n.st = TXU_S_DATA; // [R1]
          end else begin
            n.st = txu_after_data(r.wcnt + 12'h001, align);
          end
        end
      end
      TXU_S_SKIP: begin
        if (take) begin
          // whole offset words are dropped, never queued
          n.wcnt = r.wcnt + 12'h001;
          n.cnt = r.cnt - 12'h001; // [R3] [R10]
          if (r.cnt == 12'h001) begin
            if (dwords != 12'h000) begin
              n.cnt = dwords;
              n.st = TXU_S_DATA;
            end else begin
              n.st = txu_after_data(r.wcnt + 12'h001, align);
            end
          end
        end
      end
      TXU_S_DATA: begin
        if (take) begin
          n.hold = buf_data;
          n.wcnt = r.wcnt + 12'h001;
          n.cnt = r.cnt - 12'h001;
          n.first_word = 1'b0;
          // later words always begin at lane zero
          n.lane = r.first_word ? lo : 2'h0; // [R2]
          n.last_lane = (r.cnt == 12'h001) ? 2'(span - 12'h001) : 2'h3; // [R4]
          n.st = TXU_S_EMIT;
        end
      end
      TXU_S_EMIT: begin
        if (~r.mac_valid | mac_ready) begin
          n.mac_valid = 1'b1;
          n.mac_data = 8'(r.hold >> {r.lane, 3'b000});
          n.mac_last = is_last & (r.cnt == 12'h000) & (r.lane == r.last_lane);
          if (n.mac_last) begin
            n.pend_tag = r.cmd_b[TXU_CB_TAG_LSB +: 16];
          end
          if (r.lane == r.last_lane) begin
            // trailing bytes of the final word are left behind
            if (r.cnt != 12'h000) begin
              n.st = TXU_S_DATA;
            end else begin
              n.st = txu_after_data(r.wcnt, align); // [R4]
            end
          end else begin
            n.lane = r.lane + 2'h1;
          end
        end
      end
      TXU_S_PAD: begin
        if (take) begin
          n.wcnt = r.wcnt + 12'h001;
          n.st = txu_after_data(r.wcnt + 12'h001, align); // [R5]
        end
      end
      default: begin
        n.st = TXU_S_CMDA;
      end
    endcase

    // end of packet checks once the last buffer is fully consumed
    if ((r.st != TXU_S_CMDA) && (n.st == TXU_S_CMDA) && is_last) begin
      if (n.sum_len != {1'b0, r.cmd_b[TXU_CB_LEN_LSB +: 11]}) begin
        err_set = 1'b1; // [R23]
      end
      if (r.ctrl[TXU_CTRL_STORE_FORWARD] && (n.sf_use > TXU_SF_LIMIT)) begin
        err_set = 1'b1; // [R9]
      end
    end

    // ========================================================
    // status fifo
    if (stat_pop) begin
      n.rp = r.rp + 1'b1;
      n.ovr_block = 1'b0; // [R14]
    end
    if (stat_push) begin
      n.mem[r.wp] = stat_word; // [R11]
      n.wp = r.wp + 1'b1;
    end
    n.used = r.used + (TXU_STAT_AW + 1)'(stat_push) - (TXU_STAT_AW + 1)'(stat_pop);
    if (stat_lost) begin
      if (r.ctrl[TXU_CTRL_DISCARD_OVERRUN]) begin
        // status is lost; software must resync by tag
        n.ovr_block = 1'b1; // [R14] [R15]
      end else begin
        err_set = 1'b1;
      end
    end

    // ========================================================
    // apb slave, no wait states: ready in first access cycle
    n.pready = psel & ~penable & ~r.pready;
    n.pslverr = 1'b0;
    if (psel & ~penable) begin
      n.prdata = 32'h0;
      n.pslverr = (paddr > TXU_REG_PEEK) | (paddr[1:0] != 2'h0);
      case (paddr)
        TXU_REG_CTRL: n.prdata = {29'h0, r.ctrl};
        TXU_REG_FLAGS: n.prdata = {30'h0, r.underrun, r.tx_error};
        TXU_REG_STATUS: n.prdata = peek;
        TXU_REG_USED: n.prdata = r.ovr_block ? 32'h0 : {27'h0, r.used}; // [R14]
        TXU_REG_PEEK: n.prdata = peek;
        default: n.prdata = 32'h0;
      endcase
    end
    if (ctrl_wr) begin
      n.ctrl = pwdata[2:0];
    end
    if (flags_wr) begin
      if (pwdata[TXU_FLAG_TX_ERROR]) begin
        n.tx_error = 1'b0;
      end
      if (pwdata[TXU_FLAG_UNDERRUN]) begin
        n.underrun = 1'b0;
      end
    end
    // hardware sets win over a same-cycle clear
    if (err_set) begin
      n.tx_error = 1'b1;
    end
    if (stat_valid & stat_underrun) begin
      n.underrun = 1'b1; // [R22]
    end

    // ========================================================
    // flow control: a new packet waits while the status fifo is full and discard mode is off
    // a buffer already started runs to its end; each new buffer waits at its commands
    n.tx_pause = (n.used == (TXU_STAT_AW + 1)'(TXU_STAT_DEPTH)) &
                 ~n.ctrl[TXU_CTRL_DISCARD_OVERRUN]; // [R12] [R13]
    n.buf_ready = (n.st != TXU_S_EMIT) &
                  ~((n.st == TXU_S_CMDA) & n.tx_pause); // [R12]
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign buf_ready = r.buf_ready;
  assign mac_valid = r.mac_valid;
  assign mac_data = r.mac_data;
  assign mac_last = r.mac_last;
  assign tx_pause = r.tx_pause;
endmodule

// ---- txu_top_note_unused.sv ----
`timescale 1ns/1ns

// ---- txu_monitor.sv ----
`timescale 1ns/1ns
module txu_monitor
  import txu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mac_valid,
  input wire logic [7:0] mac_data,
  input wire logic mac_last,
  input wire logic mac_ready,
  input wire logic tx_pause
);
  // ==========================================================
  // shadow of the discard-overrun control bit
  logic discard_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) discard_q <= 1'b0;
    else if (ce && psel && penable && pready && pwrite && paddr == TXU_REG_CTRL)
      discard_q <= pwdata[TXU_CTRL_DISCARD_OVERRUN];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  property p_ready_one; ce && psel && !penable |=> pready ##1 !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not a single cycle after setup");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_unmapped; ce && psel && !penable && (paddr > 8'h10 || paddr[1:0] != 2'h0)
    |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_reserved; pready && psel && !pwrite && !pslverr && (paddr == TXU_REG_STATUS || paddr == TXU_REG_PEEK)
    |-> prdata[14:12] == 3'h0 && !prdata[7]; endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits set");
  property p_summary; pready && psel && !pwrite && !pslverr && (paddr == TXU_REG_STATUS || paddr == TXU_REG_PEEK)
    |-> prdata[15] == (|{prdata[11:8], prdata[2:1]}); endproperty
  a_summary: assert property (p_summary)
    else $error("error summary wrong");
  property p_discard_run; discard_q [*3] |-> !tx_pause; endproperty
  a_discard_run: assert property (p_discard_run)
    else $error("pause in discard mode");
  property p_mac_hold; mac_valid && !mac_ready |=> mac_valid && $stable(mac_data) && $stable(mac_last); endproperty
  a_mac_hold: assert property (p_mac_hold) else $error("mac byte changed while stalled");
  property p_last_valid; mac_last |-> mac_valid; endproperty
  a_last_valid: assert property (p_last_valid)
    else $error("last marker without valid byte");
  property p_resume; tx_pause && pready && psel && !pwrite && paddr == TXU_REG_STATUS |-> ##[1:4] !tx_pause; endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after status read");
endmodule

// ---- txu_host_model.sv ----
`timescale 1ns/1ns
module txu_host_model (
  input wire logic pclk,
  input wire logic buf_ready,
  output logic buf_valid,
  output logic [31:0] buf_data
);
  initial begin
    buf_valid = 1'b0;
    buf_data = 32'h0;
  end
  // ==========================================================
  // words leave exactly as the caller built the buffer
  task automatic send(input logic [31:0] w);
    buf_valid <= 1'b1;
    buf_data <= w;
    do @(posedge pclk); while (!buf_ready);
  endtask
  // released bus shows inverted data so stale words never look valid
  task automatic gap();
    buf_valid <= 1'b0;
    buf_data <= ~buf_data;
    @(posedge pclk);
  endtask
endmodule

// ---- tb_tx_buffer_unpack_and_status.sv ----
`timescale 1ns/1ns
module tb_tx_buffer_unpack_and_status;
  import txu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, buf_valid, buf_ready;
  logic mac_valid, mac_last, mac_ready, stat_valid, tx_pause, und;
  logic [7:0] paddr, mac_data;
  logic [31:0] pwdata, prdata, buf_data;
  logic [10:0] sf, sz;
  logic [15:0] tag;
  int mismatches = 0, n_tests = 0, cyc = 0;
  integer seed = 32'hfd157bde;
  logic [8:0] exp_b[$];
  logic [31:0] exp_r[$], st_q[$];
  txu_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .buf_valid(buf_valid),
    .buf_data(buf_data), .buf_ready(buf_ready), .mac_valid(mac_valid), .mac_data(mac_data), .mac_last(mac_last),
    .mac_ready(mac_ready), .stat_valid(stat_valid), .stat_lost_carrier(sf[10]), .stat_no_carrier(sf[9]),
    .stat_late_coll(sf[8]), .stat_excess_coll(sf[7]), .stat_coll_count(sf[6:3]), .stat_excess_defer(sf[2]),
    .stat_underrun(sf[1]), .stat_deferred(sf[0]), .tx_pause(tx_pause));
  txu_host_model host (.pclk(pclk), .buf_ready(buf_ready), .buf_valid(buf_valid), .buf_data(buf_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================
  // checking and reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      mismatches++;
      summarize();
    end
    if (mac_valid && mac_ready) chk({23'h0, mac_last, mac_data}, {23'h0, exp_b.pop_front()});
    if (psel && penable && pready && !pwrite) chk(prdata, exp_r.pop_front());
    mac_ready <= 1'(($random(seed) & 3) != 0);
  end
  // ==========================================================
  // drivers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_r.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic stat(input logic [10:0] f);
    sf <= f;
    stat_valid <= 1'b1;
    @(posedge pclk);
    stat_valid <= 1'b0;
    sf <= ~f;
    @(posedge pclk);
    und = und | f[1];
    st_q.push_back({tag, |{f[10:7], f[2:1]}, 3'h0, f[10:7], 1'b0, f[6:0]});
  endtask
  task automatic put(input logic [31:0] w);
    if (($random(seed) & 7) == 0) host.gap();
    host.send(w);
  endtask
  task automatic buffer(input logic [10:0] s, input logic [5:0] off, input logic [1:0] al, input logic f,
    input logic l, input logic [10:0] len);
    int nw, m, k;
    logic [31:0] w;
    nw = (off[1:0] + s + 3) / 4;
    m = (al == TXU_ALIGN_16) ? 4 : (al == TXU_ALIGN_32) ? 8 : 1;
    put({6'h0, al, 2'h0, off, 2'h0, f, l, 1'b0, s});
    put({tag, 5'h0, len});
    repeat (off[5:2]) put($random(seed));
    for (int i = 0; i < nw; i++) begin
      w = $random(seed);
      for (int j = 0; j < 4; j++) begin
        k = 4 * i + j - off[1:0];
        if (k >= 0 && k < s) exp_b.push_back({l && k == s - 1, w[8 * j +: 8]});
      end
      put(w);
    end
    repeat ((m - (2 + off[5:2] + nw) % m) % m) put($random(seed));
    host.gap();
  endtask
  task automatic drain();
    for (int i = 0; i < 400 && exp_b.size() != 0; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    mac_ready = 1'b0; stat_valid = 1'b0; sf = 11'h0; tag = 16'h0; und = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(TXU_REG_CTRL, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h02, 32'h0);
    apb(1'b1, TXU_REG_CTRL, 32'h5);
    rd(TXU_REG_CTRL, 32'h5);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      tag = 16'(i + 1);
      sz = 11'($random(seed) & 31) + 11'h1;
      buffer(sz, 6'($random(seed) & 31), 2'(i % 3), 1'b1, 1'b1, sz);
      drain();
      stat(11'($random(seed)));
    end
    tag = 16'h77;
    buffer(11'h5, 6'h03, TXU_ALIGN_16, 1'b1, 1'b0, 11'hC);
    buffer(11'h4, 6'h1E, TXU_ALIGN_4, 1'b0, 1'b0, 11'hC);
    buffer(11'h3, 6'h01, TXU_ALIGN_32, 1'b0, 1'b1, 11'hC);
    drain();
    stat(11'h0);
    rd(TXU_REG_USED, 32'h7);
    while (st_q.size() != 0) rd(TXU_REG_STATUS, st_q.pop_front());
    rd(TXU_REG_STATUS, 32'h0);
    rd(TXU_REG_FLAGS, {30'h0, und, 1'b0});
    apb(1'b1, TXU_REG_FLAGS, 32'h3);
    $display("test unpack and status done");
    tag = 16'h88;
    buffer(11'h6, 6'h0, TXU_ALIGN_4, 1'b1, 1'b1, 11'h9);
    drain();
    rd(TXU_REG_FLAGS, 32'h1);
    apb(1'b1, TXU_REG_FLAGS, 32'h3);
    repeat (16) stat(11'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, tx_pause}, 32'h1);
    rd(TXU_REG_USED, 32'h10);
    stat(11'h0);
    rd(TXU_REG_FLAGS, 32'h1);
    rd(TXU_REG_PEEK, {16'h88, 16'h0});
    rd(TXU_REG_STATUS, {16'h88, 16'h0});
    repeat (4) @(posedge pclk);
    chk({31'h0, tx_pause}, 32'h0);
    apb(1'b1, TXU_REG_FLAGS, 32'h3);
    apb(1'b1, TXU_REG_CTRL, 32'h6);
    stat(11'h0);
    stat(11'h0);
    tag = 16'h99;
    buffer(11'h2, 6'h0, TXU_ALIGN_4, 1'b1, 1'b1, 11'h2);
    drain();
    rd(TXU_REG_USED, 32'h0);
    rd(TXU_REG_FLAGS, 32'h0);
    rd(TXU_REG_STATUS, {16'h88, 16'h0});
    rd(TXU_REG_USED, 32'hF);
    $display("test status fifo done");
    summarize();
  end
endmodule
bind txu_top txu_monitor mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mac_valid(mac_valid), .mac_data(mac_data), .mac_last(mac_last), .mac_ready(mac_ready), .tx_pause(tx_pause));
